// file: sysref_cfg.svh
// Register offsets, field positions, reset values and the address width
`ifndef SYSREF_CFG_SVH
`define SYSREF_CFG_SVH
// Printed register indices; byte address is four times the index
`define IDX_SETUP_HOLD    12'h128
`define IDX_DIV_PHASE     12'h129
`define IDX_EVENT_COUNT   12'h12A
`define IDX_CHIP_SYNC     12'h1FF
`define IDX_SYSREF_CTRL   12'h120
// Control 1 fields
`define CTRL_FLAG_RST_BIT 6
`define CTRL_POL_BIT      4
`define CTRL_EDGE_BIT     3
`define CTRL_MODE_LSB     1
`define CTRL_WMASK        8'h5E
// Reset values
`define RST_STATUS        8'h00
`define RST_CTRL          8'h00
`define RST_CHIP_SYNC     8'h00
`define ADDR_BITS         14
`endif

// file: sysref_pkg.sv
// Types shared by the sysref status block
package sysref_pkg;
  typedef enum logic [1:0] {
    MODE_DISABLED   = 2'h0,
    MODE_CONTINUOUS = 2'h1,
    MODE_NSHOT      = 2'h2,
    MODE_RSVD       = 2'h3
  } sysref_mode_t;
  typedef enum logic {
    SYNC_DIVIDER_RESET = 1'h0,
    SYNC_TIMESTAMP     = 1'h1
  } sync_mode_t;
endpackage

// file: sysref_sampler.sv
// SYSREF edge detector with rising or falling edge select and arm gating
`timescale 1ns/100ps
`include "sysref_cfg.svh"
module sysref_sampler (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Inputs
  input  wire logic       sysref_in,
  input  wire logic       falling_sel,
  input  wire logic       arm,
  // Capture event
  output logic            capture_r
);
  logic prev_r;
  wire  edge_seen = falling_sel ? (prev_r & ~sysref_in)
                                : (~prev_r & sysref_in);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r    <= 1'h0;
      capture_r <= 1'h0;
    end else begin
      prev_r    <= sysref_in;
      capture_r <= arm & edge_seen;
    end
  end
endmodule

// file: sysref_capture_sync_status.sv
// SYSREF capture status, event counter and chip sync mode with AXI4-Lite
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
`include "sysref_cfg.svh"
// Summary of operation
// - Hold status sits in bits 7:4 and setup status in 3:0, both zero.
// - A four-bit code records divider phase at capture in half steps.
// - An eight-bit counter adds one per captured SYSREF.
// - The counter wraps from 255 to zero.
// - The flag reset bit clears the event counter.
// - Sync mode zero makes each capture reset the sample dividers.
// - In that mode a capture that moves a divider drops the link.
// - Sync mode one leaves dividers, link and monitor clocks alone.
// - In sync mode one each capture timestamps the passing sample.
// - Mode select codes 00 off, 01 continuous, 10 N-shot.
// - While flag reset is one the flags are held cleared.
module sysref_capture_sync_status #(
  parameter int NSHOT_W = 4
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // AXI4-Lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [13:0] s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [13:0] s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Converter side
  input  wire logic        sysref_in,
  input  wire logic [3:0]  setup_margin,
  input  wire logic [3:0]  hold_margin,
  input  wire logic [3:0]  divider_phase,
  // Sync actions
  output logic             divider_reset_r,
  output logic             link_down_r,
  output logic             timestamp_r
);
  // ==========================================================
  // Address helpers
  // ==========================================================
  function automatic logic [13:0] byte_addr(input logic [11:0] idx);
    byte_addr = {idx, 2'h0};
  endfunction

  // ==========================================================
  // Registers
  // ==========================================================
  logic [7:0] ctrl_r;
  logic [7:0] chip_sync_r;
  logic [7:0] status_r;
  logic [3:0] phase_r;
  logic [7:0] count_r;
  logic [NSHOT_W-1:0] nshot_left_r;

  wire flag_rst = ctrl_r[`CTRL_FLAG_RST_BIT];
  wire [1:0] mode_bits = ctrl_r[`CTRL_MODE_LSB +: 2];
  sysref_pkg::sysref_mode_t mode;
  assign mode = sysref_pkg::sysref_mode_t'(mode_bits);
  wire timestamp_mode = chip_sync_r[0];

  // ==========================================================
  // Capture arming (N-shot arms for one edge)
  // ==========================================================
  // Only one armed edge per N-shot write; the ignore count is not kept
  wire arm = (mode == sysref_pkg::MODE_CONTINUOUS)
          || (mode == sysref_pkg::MODE_NSHOT && nshot_left_r != '0);
  logic capture;
  sysref_sampler u_samp (
    .clk         (clk),
    .rst_n       (rst_n),
    .sysref_in   (sysref_in),
    .falling_sel (ctrl_r[`CTRL_POL_BIT]),
    .arm         (arm),
    .capture_r   (capture)
  );

  // ==========================================================
  // AXI4-Lite write path
  // ==========================================================
  logic        aw_held_r;
  logic        w_held_r;
  logic [13:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire wr_go   = aw_held_r & w_held_r & ~s_axi_bvalid;
  wire wr_ctrl = wr_go & wstrb_r[0]
               & (awaddr_r == byte_addr(`IDX_SYSREF_CTRL));
  wire wr_sync = wr_go & wstrb_r[0]
               & (awaddr_r == byte_addr(`IDX_CHIP_SYNC));
  wire wr_known = (awaddr_r == byte_addr(`IDX_SYSREF_CTRL))
               || (awaddr_r == byte_addr(`IDX_CHIP_SYNC))
               || (awaddr_r == byte_addr(`IDX_SETUP_HOLD))
               || (awaddr_r == byte_addr(`IDX_DIV_PHASE))
               || (awaddr_r == byte_addr(`IDX_EVENT_COUNT));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'h0;
      s_axi_wready  <= 1'h0;
      aw_held_r     <= 1'h0;
      w_held_r      <= 1'h0;
      awaddr_r      <= 14'h0;
      wdata_r       <= 32'h0;
      wstrb_r       <= 4'h0;
      s_axi_bvalid  <= 1'h0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= ~aw_held_r & ~aw_take;
      s_axi_wready  <= ~w_held_r & ~w_take;
      if (aw_take) begin
        aw_held_r <= 1'h1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_r <= 1'h1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_r    <= 1'h0;
        w_held_r     <= 1'h0;
        s_axi_bvalid <= 1'h1;
        s_axi_bresp  <= wr_known ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'h0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r      <= `RST_CTRL;
      chip_sync_r <= `RST_CHIP_SYNC;
    end else begin
      if (wr_ctrl)
        ctrl_r <= wdata_r[7:0] & `CTRL_WMASK;
      if (wr_sync)
        chip_sync_r <= {7'h0, wdata_r[0]};
    end
  end

  // ==========================================================
  // Capture status, counter and sync actions
  // ==========================================================
  wire [7:0] status_nxt = {hold_margin, setup_margin};
  wire [7:0] count_nxt  = count_r + 8'h01;
  wire nshot_load = wr_ctrl
      && (wdata_r[`CTRL_MODE_LSB +: 2] == 2'(sysref_pkg::MODE_NSHOT));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_r     <= `RST_STATUS;
      phase_r      <= 4'h0;
      count_r      <= 8'h00;
      nshot_left_r <= '0;
    end else begin
      if (flag_rst) begin
        status_r <= `RST_STATUS;
        phase_r  <= 4'h0;
        count_r  <= 8'h00;
      end else if (capture) begin
        status_r <= status_nxt;
        phase_r  <= divider_phase;
        count_r  <= count_nxt;
      end
      if (nshot_load)
        nshot_left_r <= NSHOT_W'(1);
      else if (capture && mode == sysref_pkg::MODE_NSHOT)
        nshot_left_r <= nshot_left_r - NSHOT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divider_reset_r <= 1'h0;
      link_down_r     <= 1'h0;
      timestamp_r     <= 1'h0;
    end else begin
      divider_reset_r <= capture & ~timestamp_mode;
      link_down_r     <= capture & ~timestamp_mode
                       & (divider_phase != 4'h0);
      timestamp_r     <= capture & timestamp_mode;
    end
  end

  // ==========================================================
  // AXI4-Lite read path
  // ==========================================================
  // Counter may move under a read while mode select is continuous or N-shot, or in any mode when flag reset clears it
  logic [7:0] rd_word;
  logic       rd_ok;
  always_comb begin
    rd_ok   = 1'h1;
    rd_word = 8'h00;
    unique case (s_axi_araddr)
      byte_addr(`IDX_SETUP_HOLD):  rd_word = status_r;
      byte_addr(`IDX_DIV_PHASE):   rd_word = {4'h0, phase_r};
      byte_addr(`IDX_EVENT_COUNT): rd_word = count_r;
      byte_addr(`IDX_SYSREF_CTRL): rd_word = ctrl_r;
      byte_addr(`IDX_CHIP_SYNC):   rd_word = chip_sync_r;
      default:                     rd_ok   = 1'h0;
    endcase
  end
  wire ar_take = s_axi_arvalid & s_axi_arready;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'h0;
      s_axi_rvalid  <= 1'h0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~ar_take & ~s_axi_arready;
      if (ar_take) begin
        s_axi_rvalid <= 1'h1;
        s_axi_rdata  <= {24'h0, rd_word};
        s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'h0;
      end
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  count_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    capture && !flag_rst |=> count_r == $past(count_r) + 8'h01)
    else $error("event count did not step");
  count_clear_a: assert property (@(posedge clk)
    disable iff (!rst_n) flag_rst |=> count_r == 8'h00)
    else $error("event count not cleared");
  flags_held_a: assert property (@(posedge clk) disable iff (!rst_n)
    flag_rst |=> status_r == 8'h00 && phase_r == 4'h0)
    else $error("flags not held in reset");
  status_hold_a: assert property (@(posedge clk)
    disable iff (!rst_n)
    !capture && !flag_rst |=> $stable(status_r) && $stable(phase_r))
    else $error("status moved without capture");
  phase_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    capture && !flag_rst |=> phase_r == $past(divider_phase))
    else $error("phase not captured");
  div_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    capture && !timestamp_mode |=> divider_reset_r && !timestamp_r)
    else $error("divider reset missing");
  ts_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
    capture && timestamp_mode |=> timestamp_r && !divider_reset_r
      && !link_down_r)
    else $error("timestamp mode disturbed dividers");
  link_down_a: assert property (@(posedge clk) disable iff (!rst_n)
    link_down_r |-> $past(capture) && $past(divider_phase) != 4'h0)
    else $error("link dropped without phase move");
  disarmed_a: assert property (@(posedge clk) disable iff (!rst_n)
    mode == sysref_pkg::MODE_DISABLED |=> !capture)
    else $error("capture while disabled");
  status_load_a: assert property (@(posedge clk)
    disable iff (!rst_n)
    capture && !flag_rst |=> status_r == {$past(hold_margin),
      $past(setup_margin)})
    else $error("status fields not captured");
  count_wrap_a: assert property (@(posedge clk)
    disable iff (!rst_n)
    capture && !flag_rst && count_r == 8'hFF |=> count_r == 8'h00)
    else $error("event count did not wrap");
  ts_pulse_a: assert property (@(posedge clk)
    disable iff (!rst_n)
    timestamp_r |-> $past(capture) && $past(timestamp_mode))
    else $error("timestamp without capture");
  nshot_spent_a: assert property (@(posedge clk)
    disable iff (!rst_n)
    capture && mode == sysref_pkg::MODE_NSHOT && !nshot_load
      |=> nshot_left_r == '0)
    else $error("N-shot capture left the arm set");

  // ==========================================================
  // Bus answer checks
  // ==========================================================
  // An answer raised early would hand the master a stale register
  wr_answer_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(s_axi_bvalid) |-> $past(aw_held_r) && $past(w_held_r))
    else $error("write answered before address and data");
  rd_answer_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(s_axi_rvalid) |-> $past(ar_take))
    else $error("read answered without a request");
endmodule

// file: sysref_source_model.sv
// Clock generator model driving SYSREF and the capture margins
`timescale 1ns/100ps
module sysref_source_model (
  // Clock
  input  wire logic       clk,
  // Converter side
  output logic            sysref_in,
  output logic [3:0]      setup_margin,
  output logic [3:0]      hold_margin,
  output logic [3:0]      divider_phase
);
  // ==========================================================
  // Idle levels
  initial begin
    sysref_in = 1'b0;
    setup_margin = 4'h0;
    hold_margin = 4'h0;
    divider_phase = 4'h0;
  end
  // ==========================================================
  // One SYSREF pulse
  // Margins stay level past the pulse so capture sees settled values
  task automatic pulse(input logic [3:0] s, input logic [3:0] h,
                       input logic [3:0] p);
    @(posedge clk);
    setup_margin <= s;
    hold_margin <= h;
    divider_phase <= p;
    sysref_in <= 1'b1;
    repeat (3) @(posedge clk);
    sysref_in <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
endmodule

// file: tb_sysref_capture_sync_status.sv
// Testbench for the SYSREF capture status block
`timescale 1ns/100ps
module tb_sysref_capture_sync_status;
  // ==========================================================
  // Signals
  logic        clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, sysref_in;
  logic        divider_reset_r, link_down_r, timestamp_r;
  logic [13:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, setup_margin, hold_margin, divider_phase;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          error_cnt = 0, cmp_count = 0, n_dr = 0, n_ld = 0, n_ts = 0;
  int          i;
  localparam logic [13:0] A_SH = 14'h4A0, A_PH = 14'h4A4, A_CNT = 14'h4A8;
  localparam logic [13:0] A_CTRL = 14'h480, A_SYNC = 14'h7FC;
  // ==========================================================
  // Instances
  sysref_capture_sync_status i_sysref_capture_sync_status (
    .clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .sysref_in, .setup_margin, .hold_margin,
    .divider_phase, .divider_reset_r, .link_down_r, .timestamp_r);
  sysref_source_model i_sysref_source_model (
    .clk, .sysref_in, .setup_margin, .hold_margin, .divider_phase);
  always #5 clk = ~clk;
  // Pulse outputs last one cycle, so count them at every edge
  always @(posedge clk) begin
    if (divider_reset_r === 1'b1) n_dr++;
    if (link_down_r === 1'b1) n_ld++;
    if (timestamp_r === 1'b1) n_ts++;
  end
  // ==========================================================
  // Tasks
  task automatic end_sim;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 40) begin
      error_cnt++;
      $display("ERROR %0t bus handshake timeout", $time);
      end_sim;
    end
  endtask
  task automatic wr(input logic [13:0] a, input logic [7:0] d,
                    input logic [1:0] r);
    int n;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
    end
    s_axi_bready <= 1'b0;
    tmo(n);
    chk(s_axi_bresp, r);
  endtask
  // Data is only compared when an OKAY answer is expected
  task automatic rd(input logic [13:0] a, input logic [7:0] e,
                    input logic [1:0] r);
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
    end
    s_axi_rready <= 1'b0;
    tmo(n);
    chk(s_axi_rresp, r);
    if (r == 2'h0) chk(s_axi_rdata, {24'h0, e});
  endtask
  // ==========================================================
  // Sequence
  initial begin
    {clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(A_SH, 8'h00, 2'h0);
    rd(A_PH, 8'h00, 2'h0);
    rd(A_CNT, 8'h00, 2'h0);
    rd(A_SYNC, 8'h00, 2'h0);
    rd(14'h100, 8'h00, 2'h2);
    wr(14'h104, 8'h11, 2'h2);
    wr(A_CTRL, 8'h02, 2'h0);
    i_sysref_source_model.pulse(4'h5, 4'hA, 4'h3);
    wr(A_CTRL, 8'h00, 2'h0);
    rd(A_SH, 8'hA5, 2'h0);
    rd(A_PH, 8'h03, 2'h0);
    rd(A_CNT, 8'h01, 2'h0);
    chk(n_dr, 1);
    chk(n_ld, 1);
    i_sysref_source_model.pulse(4'h1, 4'h1, 4'h1);
    wr(A_CNT, 8'h55, 2'h0);
    rd(A_SH, 8'hA5, 2'h0);
    rd(A_CNT, 8'h01, 2'h0);
    wr(A_SYNC, 8'h01, 2'h0);
    wr(A_CTRL, 8'h02, 2'h0);
    i_sysref_source_model.pulse(4'h2, 4'h1, 4'h6);
    chk(n_dr, 1);
    chk(n_ld, 1);
    chk(n_ts, 1);
    wr(A_SYNC, 8'h00, 2'h0);
    i_sysref_source_model.pulse(4'h0, 4'h0, 4'h0);
    chk(n_dr, 2);
    chk(n_ld, 1);
    wr(A_CTRL, 8'h04, 2'h0);
    repeat (2) i_sysref_source_model.pulse(4'h3, 4'h4, 4'h0);
    wr(A_CTRL, 8'h06, 2'h0);
    i_sysref_source_model.pulse(4'h7, 4'h7, 4'h0);
    wr(A_CTRL, 8'h00, 2'h0);
    rd(A_CNT, 8'h04, 2'h0);
    rd(A_SH, 8'h43, 2'h0);
    wr(A_CTRL, 8'h40, 2'h0);
    rd(A_CNT, 8'h00, 2'h0);
    rd(A_SH, 8'h00, 2'h0);
    wr(A_CTRL, 8'h02, 2'h0);
    for (i = 0; i < 255; i++) i_sysref_source_model.pulse(4'h1, 4'h2, 4'h0);
    wr(A_CTRL, 8'h00, 2'h0);
    rd(A_CNT, 8'hFF, 2'h0);
    wr(A_CTRL, 8'h02, 2'h0);
    i_sysref_source_model.pulse(4'h1, 4'h2, 4'h0);
    wr(A_CTRL, 8'h00, 2'h0);
    rd(A_CNT, 8'h00, 2'h0);
    // Polarity changes only while disabled; the falling edge is captured
    wr(A_CTRL, 8'h10, 2'h0);
    wr(A_CTRL, 8'h12, 2'h0);
    i_sysref_source_model.pulse(4'h2, 4'h3, 4'h0);
    wr(A_CTRL, 8'h00, 2'h0);
    rd(A_CNT, 8'h01, 2'h0);
    rd(A_SH, 8'h32, 2'h0);
    end_sim;
  end
endmodule
